/* hw/pbc_pkg.sv */
package pbc_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS    = 40;
    localparam real         SW_RESET_TIME_MS = 1.2;
    localparam int unsigned SW_RESET_CYCLES  = int'($ceil(SW_RESET_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int unsigned RST_CNT_W        = 16;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [4:0] ADDR_CONTROL   = 5'h00;
    localparam logic [4:0] ADDR_PARTNER   = 5'h05;
    localparam logic [4:0] ADDR_EXPANSION = 5'h06;
    localparam logic [4:0] ADDR_NP_TX     = 5'h07;
    localparam logic [4:0] ADDR_NP_RX     = 5'h08;
    localparam logic [4:0] ADDR_GIG_CTRL  = 5'h09;
    localparam logic [4:0] ADDR_GIG_STAT  = 5'h0a;
    localparam logic [4:0] ADDR_GIG_EXT   = 5'h0f;
    localparam logic [4:0] ADDR_STRAP     = 5'h10;
    localparam logic [4:0] ADDR_SUPPORT   = 5'h11;

    localparam logic [15:0] GIG_EXT_VALUE = 16'h3000;
    localparam logic [15:0] WORD_ZERO     = 16'h0000;

    // ************************************************************
    // Serial management framing
    // ************************************************************
    localparam logic [5:0] PREAMBLE_BITS = 6'h20;
    localparam logic [5:0] HDR_BITS      = 6'h0d;
    localparam logic [5:0] TA_BITS       = 6'h02;
    localparam logic [5:0] DATA_BITS     = 6'h10;
    localparam logic [1:0] OP_READ       = 2'h2;
    localparam logic [1:0] OP_WRITE      = 2'h1;

    // Link speed codes
    localparam logic [1:0] SPD_10   = 2'h0;
    localparam logic [1:0] SPD_100  = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;

    // ************************************************************
    // Register layouts
    // ************************************************************
    typedef struct packed {
        logic       sw_reset;
        logic       loopback;
        logic       speed_lo;
        logic       negotiation_enable;
        logic       power_down;
        logic       isolate;
        logic       restart;
        logic       duplex;
        logic       coll_test;
        logic       speed_hi;
        logic [5:0] rsvd;
    } pbc_ctl_s;

    typedef struct packed {
        logic        next_page;
        logic        rsvd;
        logic        msg_page;
        logic        ack_two;
        logic        toggle;
        logic [10:0] page_message_field;
    } pbc_np_s;

    typedef struct packed {
        logic [2:0] test_mode;
        logic       ms_manual;
        logic       ms_value;
        logic       port_type;
        logic       adv_fdx;
        logic       adv_hdx;
        logic [7:0] rsvd;
    } pbc_gig_s;

    typedef struct packed {
        logic [4:0] phy_addr;
        logic       nc_mode;
        logic       ms_manual;
        logic       an_ena;
        logic       ms_value;
        logic [1:0] rsvd;
        logic       hdx1000;
        logic       fdx1000;
        logic       fdx100;
        logic [1:0] sel_speed;
    } pbc_strap_s;

    typedef struct packed {
        logic       start_lo;
        logic [1:0] op;
        logic [4:0] phy;
        logic [4:0] reg_addr;
    } pbc_hdr_s;

    // ************************************************************
    // Pin groups
    // ************************************************************
    typedef struct packed {
        logic [7:0] txd;
        logic       tx_en;
        logic       tx_er;
    } pbc_tx_s;

    typedef struct packed {
        logic       tx_clk;
        logic       rx_clk;
        logic [7:0] rxd;
        logic       rx_dv;
        logic       rx_er;
        logic       col;
        logic       crs;
    } pbc_rx_s;

    typedef struct packed {
        logic [15:0] partner_ability;
        logic        parallel_detect_fault;
        logic        partner_pages_capable;
        logic        local_pages_capable;
        logic        page_received;
        logic        partner_negotiation_capable;
        logic [15:0] gigabit_status;
        logic [1:0]  res_speed;
        logic        res_link;
        logic        res_duplex;
        logic        np_rx_valid;
        pbc_np_s     np_rx;
        logic        an_initiated;
    } pbc_neg_s;

    typedef struct packed {
        logic       an_enable;
        logic [1:0] speed;
        logic       full_duplex;
        logic       power_down;
        logic       loopback;
        logic       isolate;
        logic       coll_test;
    } pbc_cfg_s;

    typedef enum logic [1:0] {MD_PRE, MD_HDR, MD_TA, MD_DATA} pbc_md_e;

endpackage

/* hw/pbc_mgmt_regs.sv */
`timescale 1ns/100ps
// Overview of operation
// - Reset bit restores defaults, reads one meanwhile
// - Reset ends when negotiation or forced mode starts
// - Loopback routes transmit path into receive path
// - Forced speed from bits six and thirteen
// - Speed bit default from strap when negotiation off
// - Negotiation enable overrides forced speed and duplex
// - Power down keeps only management alive
// - Isolate ignores transmit inputs, management still works
// - Isolate floats all MAC facing outputs
// - Restart write ignored while negotiation disabled
// - Restart reads one until negotiation initiated
// - Writing zero to restart changes nothing
// - Next page transmit register layout
// - Next page receive register, resets to zero
// - Extended status reports gigabit twisted pair only
// - Duplex bit applies only when negotiation off
// - Collision test echoes transmit enable on collision
// - Reserved control bits ignore writes, read zero
module pbc_mgmt_regs
    import pbc_pkg::*;
#(
    parameter int unsigned SW_RESET_CYC = SW_RESET_CYCLES
) (
    input  wire logic       MCLK,
    input  wire logic       RST_N,
    input  wire logic       MDC,
    input  wire logic       MDIO_I,
    output logic            MDIO_O,
    output logic            MDIO_OE,
    input  wire pbc_strap_s STRAPS,
    input  wire pbc_tx_s    MAC_TX,
    output pbc_rx_s         MAC_RX,
    output logic            MAC_RX_OE,
    input  wire pbc_rx_s    LINE_RX,
    output pbc_tx_s         LINE_TX,
    input  wire pbc_neg_s   NEG,
    output logic            AN_START,
    output pbc_cfg_s        LINK_CFG
);

    localparam logic [RST_CNT_W-1:0] RST_LOAD = RST_CNT_W'(SW_RESET_CYC - 1);

    typedef struct packed {
        pbc_ctl_s             ctl;
        pbc_np_s              np_tx;
        pbc_np_s              np_rx;
        pbc_gig_s             gig;
        pbc_strap_s           strap;
        pbc_strap_s           pins;
        logic                 straps_taken;
        logic [RST_CNT_W-1:0] rst_cnt;
        logic                 an_start;
        pbc_rx_s              mac_rx;
        pbc_tx_s              line_tx;
        logic                 mac_oe;
        pbc_md_e              md;
        logic [5:0]           md_cnt;
        pbc_hdr_s             md_hdr;
        logic [16:0]          md_sh;
        logic                 mdio_o;
        logic                 mdio_oe;
        logic                 mdc_q;
    } pbc_state_s;

    pbc_state_s q;
    pbc_state_s next_q;

    // ************************************************************
    // Defaults
    // ************************************************************
    function automatic pbc_ctl_s ctl_default(input pbc_strap_s s);
        pbc_ctl_s c;
        c = '0;
        c.negotiation_enable = s.an_ena;
        // Forced defaults come from straps only when negotiation is strapped off
        c.speed_lo = s.an_ena ? 1'b1 : s.sel_speed[0];
        c.speed_hi = s.an_ena ? 1'b0 : s.sel_speed[1];
        c.duplex   = s.an_ena ? 1'b1 : s.fdx100;
        return c;
    endfunction

    function automatic pbc_gig_s gig_default(input pbc_strap_s s);
        pbc_gig_s g;
        g = '0;
        g.ms_manual = s.ms_manual;
        g.ms_value  = s.ms_value;
        g.adv_fdx   = s.fdx1000;
        g.adv_hdx   = s.hdx1000;
        return g;
    endfunction

    function automatic logic [1:0] forced_speed(input pbc_ctl_s c);
        logic [1:0] sel;
        sel = {c.speed_hi, c.speed_lo};
        case (sel)
            SPD_1000: forced_speed = SPD_1000;
            SPD_100:  forced_speed = SPD_100;
            default:  forced_speed = SPD_10;
        endcase
    endfunction

    // ************************************************************
    // Read multiplexer
    // ************************************************************
    function automatic logic [15:0] rd_word(input logic [4:0] a, input pbc_state_s s, input pbc_neg_s g);
        pbc_ctl_s c;
        c = s.ctl;
        c.rsvd = '0;
        case (a)
            ADDR_CONTROL:   rd_word = c;
            ADDR_PARTNER:   rd_word = g.partner_ability;
            ADDR_EXPANSION: rd_word = {11'h000, g.parallel_detect_fault, g.partner_pages_capable,
                                       g.local_pages_capable, g.page_received, g.partner_negotiation_capable};
            ADDR_NP_TX:     rd_word = s.np_tx;
            ADDR_NP_RX:     rd_word = s.np_rx;
            ADDR_GIG_CTRL:  rd_word = s.gig;
            ADDR_GIG_STAT:  rd_word = g.gigabit_status;
            ADDR_GIG_EXT:   rd_word = GIG_EXT_VALUE;
            ADDR_STRAP:     rd_word = s.strap;
            ADDR_SUPPORT:   rd_word = {11'h000, g.res_speed, g.res_link, g.res_duplex, 1'b0};
            default:        rd_word = WORD_ZERO;
        endcase
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic        rise;
        logic        fall;
        logic        wr_en;
        logic [15:0] wdata;
        logic        rs_keep;
        pbc_hdr_s    nh;
        pbc_ctl_s    w;
        pbc_tx_s     tx_eff;
        rise    = 1'b0;
        fall    = 1'b0;
        wr_en   = 1'b0;
        wdata   = '0;
        rs_keep = 1'b0;
        nh      = '0;
        w       = '0;
        tx_eff  = '0;
        next_q  = q;
        next_q.an_start = 1'b0;
        next_q.mdc_q    = MDC;
        rise = MDC & ~q.mdc_q;
        fall = ~MDC & q.mdc_q;

        // Straps are caught once, on the first edge after reset release
        if (!q.straps_taken) begin
            next_q.straps_taken = 1'b1;
            next_q.pins         = STRAPS;
            next_q.strap        = STRAPS;
            next_q.ctl          = ctl_default(STRAPS);
            next_q.gig          = gig_default(STRAPS);
        end

        // Serial management frame: management stays alive in power down and isolate
        if (rise) begin
            case (q.md)
                MD_PRE: begin
                    if (MDIO_I) begin
                        if (q.md_cnt != PREAMBLE_BITS) begin
                            next_q.md_cnt = q.md_cnt + 6'h01;
                        end
                    end else if (q.md_cnt == PREAMBLE_BITS) begin
                        next_q.md     = MD_HDR;
                        next_q.md_cnt = '0;
                    end else begin
                        next_q.md_cnt = '0;
                    end
                end
                MD_HDR: begin
                    nh = pbc_hdr_s'({q.md_hdr[HDR_BITS-2:0], MDIO_I});
                    next_q.md_hdr = nh;
                    next_q.md_cnt = q.md_cnt + 6'h01;
                    if (q.md_cnt == HDR_BITS - 6'h01) begin
                        next_q.md_cnt = '0;
                        if (nh.start_lo && nh.phy == q.strap.phy_addr && (nh.op == OP_READ || nh.op == OP_WRITE)) begin
                            next_q.md    = MD_TA;
                            next_q.md_sh = {1'b0, rd_word(nh.reg_addr, q, NEG)};
                        end else begin
                            next_q.md = MD_PRE;
                        end
                    end
                end
                MD_TA: begin
                    next_q.md_cnt = q.md_cnt + 6'h01;
                    if (q.md_cnt == TA_BITS - 6'h01) begin
                        next_q.md     = MD_DATA;
                        next_q.md_cnt = '0;
                    end
                end
                MD_DATA: begin
                    next_q.md_cnt = q.md_cnt + 6'h01;
                    if (q.md_hdr.op == OP_WRITE) begin
                        next_q.md_sh = {q.md_sh[15:0], MDIO_I};
                    end
                    if (q.md_cnt == DATA_BITS - 6'h01) begin
                        next_q.md     = MD_PRE;
                        next_q.md_cnt = '0;
                        wr_en         = (q.md_hdr.op == OP_WRITE);
                        wdata         = {q.md_sh[14:0], MDIO_I};
                    end
                end
                default: begin
                    next_q.md     = MD_PRE;
                    next_q.md_cnt = '0;
                end
            endcase
        end

        // Read data changes after the falling edge so it is stable at the next rising one
        if (fall) begin
            // Only a read frame hands the line to the device; a write keeps the manager driving
            if (q.md_hdr.op == OP_READ && ((q.md == MD_TA && q.md_cnt == TA_BITS - 6'h01) || q.md == MD_DATA)) begin
                next_q.mdio_oe = 1'b1;
                next_q.mdio_o  = q.md_sh[16];
                next_q.md_sh   = {q.md_sh[15:0], 1'b0};
            end else begin
                next_q.mdio_oe = 1'b0;
                next_q.mdio_o  = 1'b0;
            end
        end

        // ************************************************************
        // Negotiation handshakes
        // ************************************************************
        if (NEG.an_initiated) begin
            next_q.ctl.restart = 1'b0;
        end
        if (NEG.np_rx_valid) begin
            next_q.np_rx = NEG.np_rx;
        end

        if (q.ctl.sw_reset) begin
            if (q.rst_cnt == '0) begin
                // Finishing means negotiation is kicked off, or forced mode entered
                next_q.ctl.sw_reset = 1'b0;
                next_q.an_start     = q.ctl.negotiation_enable;
            end else begin
                next_q.rst_cnt = q.rst_cnt - RST_CNT_W'(1);
            end
        end

        // ************************************************************
        // Register writes
        // ************************************************************
        if (wr_en) begin
            case (q.md_hdr.reg_addr)
                ADDR_CONTROL: begin
                    w = pbc_ctl_s'(wdata);
                    if (w.sw_reset) begin
                        next_q.ctl          = ctl_default(q.pins);
                        next_q.ctl.sw_reset = 1'b1;
                        next_q.np_tx        = '0;
                        next_q.np_rx        = '0;
                        next_q.gig          = gig_default(q.pins);
                        next_q.strap        = q.pins;
                        next_q.rst_cnt      = RST_LOAD;
                    end else begin
                        rs_keep             = next_q.ctl.restart;
                        next_q.ctl          = w;
                        next_q.ctl.rsvd     = '0;
                        next_q.ctl.sw_reset = q.ctl.sw_reset;
                        // A zero written to restart never cancels a pending one; set beats clear
                        next_q.ctl.restart  = rs_keep | (w.restart & w.negotiation_enable);
                        if (w.restart && w.negotiation_enable) begin
                            next_q.an_start = 1'b1;
                        end
                    end
                end
                ADDR_NP_TX: begin
                    next_q.np_tx      = pbc_np_s'(wdata);
                    next_q.np_tx.rsvd = 1'b0;
                end
                ADDR_GIG_CTRL: begin
                    next_q.gig      = pbc_gig_s'(wdata);
                    next_q.gig.rsvd = '0;
                end
                ADDR_STRAP: begin
                    next_q.strap      = pbc_strap_s'(wdata);
                    next_q.strap.rsvd = '0;
                end
                default: begin
                end
            endcase
        end

        // ************************************************************
        // MAC datapath
        // ************************************************************
        tx_eff         = q.ctl.isolate ? pbc_tx_s'('0) : MAC_TX;
        next_q.line_tx = '0;
        next_q.mac_rx  = '0;
        next_q.mac_oe  = ~q.ctl.isolate;
        if (!q.ctl.power_down) begin
            if (q.ctl.loopback) begin
                // Nothing goes to the line during loopback
                next_q.mac_rx.tx_clk = LINE_RX.tx_clk;
                next_q.mac_rx.rx_clk = LINE_RX.tx_clk;
                next_q.mac_rx.rxd    = tx_eff.txd;
                next_q.mac_rx.rx_dv  = tx_eff.tx_en;
                next_q.mac_rx.rx_er  = tx_eff.tx_er;
                next_q.mac_rx.crs    = tx_eff.tx_en;
            end else begin
                next_q.mac_rx  = LINE_RX;
                next_q.line_tx = tx_eff;
            end
            if (q.ctl.coll_test) begin
                // One clock is far inside the 512 bit time limit at every speed
                next_q.mac_rx.col = tx_eff.tx_en;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign MDIO_O    = q.mdio_o;
    assign MDIO_OE   = q.mdio_oe;
    assign MAC_RX    = q.mac_rx;
    assign MAC_RX_OE = q.mac_oe;
    assign LINE_TX   = q.line_tx;
    assign AN_START  = q.an_start;

    always_comb begin
        LINK_CFG             = '0;
        LINK_CFG.an_enable   = q.ctl.negotiation_enable;
        LINK_CFG.speed       = q.ctl.negotiation_enable ? NEG.res_speed : forced_speed(q.ctl);
        LINK_CFG.full_duplex = q.ctl.negotiation_enable ? NEG.res_duplex : q.ctl.duplex;
        LINK_CFG.power_down  = q.ctl.power_down;
        LINK_CFG.loopback    = q.ctl.loopback;
        LINK_CFG.isolate     = q.ctl.isolate;
        LINK_CFG.coll_test   = q.ctl.coll_test;
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    // Helper decode for the write assertions only
    logic     wr_ctl_any;
    pbc_ctl_s wdata_ctl;
    assign wr_ctl_any = (MDC & ~q.mdc_q) && q.md == MD_DATA && q.md_cnt == DATA_BITS - 6'h01
                        && q.md_hdr.op == OP_WRITE && q.md_hdr.reg_addr == ADDR_CONTROL;
    assign wdata_ctl  = pbc_ctl_s'({q.md_sh[14:0], MDIO_I});
    AST_RESET_HOLDS: assert property (@(posedge MCLK) disable iff (!RST_N)
        $rose(q.ctl.sw_reset) |-> q.ctl.sw_reset[*8])
        else $error("Software reset bit dropped too early");
    AST_RESET_ENDS: assert property (@(posedge MCLK) disable iff (!RST_N)
        (q.ctl.sw_reset && q.rst_cnt == '0 && !wr_ctl_any) |=> !q.ctl.sw_reset && (AN_START == q.ctl.negotiation_enable))
        else $error("Software reset did not finish into negotiation or forced mode");
    AST_LOOPBACK: assert property (@(posedge MCLK) disable iff (!RST_N)
        (q.ctl.loopback && !q.ctl.power_down && !q.ctl.isolate) |=>
            (MAC_RX.rxd == $past(MAC_TX.txd) && MAC_RX.rx_dv == $past(MAC_TX.tx_en) && LINE_TX == '0))
        else $error("Loopback data mismatch");
    AST_FORCED_SPEED: assert property (@(posedge MCLK) disable iff (!RST_N)
        (!q.ctl.negotiation_enable && q.ctl.speed_hi && !q.ctl.speed_lo) |-> LINK_CFG.speed == SPD_1000)
        else $error("Forced gigabit speed not applied");
    AST_AN_OVERRIDES: assert property (@(posedge MCLK) disable iff (!RST_N)
        q.ctl.negotiation_enable |-> (LINK_CFG.speed == NEG.res_speed && LINK_CFG.full_duplex == NEG.res_duplex))
        else $error("Forced bits leaked while negotiating");
    AST_POWER_DOWN: assert property (@(posedge MCLK) disable iff (!RST_N)
        q.ctl.power_down |=> (LINE_TX == '0 && MAC_RX == '0))
        else $error("Datapath active in power down");
    AST_ISOLATE: assert property (@(posedge MCLK) disable iff (!RST_N)
        q.ctl.isolate |=> (!MAC_RX_OE && LINE_TX == '0))
        else $error("Isolated port still drives");
    AST_RESTART_IGNORED: assert property (@(posedge MCLK) disable iff (!RST_N)
        (wr_ctl_any && !wdata_ctl.negotiation_enable && !q.ctl.restart) |=> (!q.ctl.restart && !AN_START))
        else $error("Restart honoured while negotiation disabled");
    // A software reset legitimately returns a pending restart to its default
    AST_RESTART_HOLDS: assert property (@(posedge MCLK) disable iff (!RST_N)
        (q.ctl.restart && !NEG.an_initiated && !q.ctl.sw_reset && !(wr_ctl_any && wdata_ctl.sw_reset))
            |=> q.ctl.restart)
        else $error("Restart bit cleared before negotiation initiated");
    AST_COLL_TEST: assert property (@(posedge MCLK) disable iff (!RST_N)
        (q.ctl.coll_test && !q.ctl.power_down && !q.ctl.isolate && MAC_TX.tx_en) |=> MAC_RX.col)
        else $error("Collision test did not echo transmit enable");

endmodule

/* sim/pbc_sme_model.sv */
`timescale 1ns/100ps
module pbc_sme_model
    import pbc_pkg::*;
(
    input  wire logic MCLK,
    input  wire logic MDIO,
    output logic      MDC,
    output logic      DRV,
    output logic      DRV_EN
);
    initial begin
        MDC = 1'b0;
        DRV = 1'b1;
        DRV_EN = 1'b0;
    end
    // Two core clocks per half period so the device sees every management edge
    task automatic bit_cyc(input logic d, input logic en, output logic q);
        MDC <= 1'b0;
        DRV <= d;
        DRV_EN <= en;
        repeat (2) @(posedge MCLK);
        MDC <= 1'b1;
        repeat (2) @(posedge MCLK);
        q = MDIO;
    endtask
    // Full preamble on every frame; line released during a read turnaround
    task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
        logic [45:0] f;
        logic        q;
        f = {32'hFFFF_FFFF, 2'h1, op, 5'h01, ra};
        for (int i = 45; i >= 0; i--) bit_cyc(f[i], 1'b1, q);
        for (int i = 1; i >= 0; i--) bit_cyc(i[0], op == OP_WRITE, q);
        for (int i = 15; i >= 0; i--) begin
            bit_cyc(wd[i], op == OP_WRITE, q);
            rd[i] = q;
        end
        bit_cyc(1'b1, 1'b0, q);
    endtask
endmodule

/* sim/phy_basic_control_registers_test.sv */
`timescale 1ns/100ps
module phy_basic_control_registers_test;
    import pbc_pkg::*;
    localparam int unsigned RCYC = 400;
    logic        mclk, rst_n, mdc, mdio, mdio_o, mdio_oe, drv, den, an_start, rx_oe;
    pbc_tx_s     mac_tx, line_tx;
    pbc_rx_s     mac_rx, line_rx;
    pbc_neg_s    neg;
    pbc_cfg_s    cfg;
    logic [15:0] rd;
    int          err_count = 0, comparisons = 0, starts = 0;
    // Pull-up holds the line high when nobody drives it
    assign mdio = mdio_oe ? mdio_o : (den ? drv : 1'b1);
    pbc_mgmt_regs #(.SW_RESET_CYC(RCYC)) dut (.MCLK(mclk), .RST_N(rst_n), .MDC(mdc), .MDIO_I(mdio),
        .MDIO_O(mdio_o), .MDIO_OE(mdio_oe), .STRAPS(16'h0806), .MAC_TX(mac_tx), .MAC_RX(mac_rx),
        .MAC_RX_OE(rx_oe), .LINE_RX(line_rx), .LINE_TX(line_tx), .NEG(neg), .AN_START(an_start), .LINK_CFG(cfg));
    pbc_sme_model sme (.MCLK(mclk), .MDIO(mdio), .MDC(mdc), .DRV(drv), .DRV_EN(den));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) if (an_start === 1'b1) starts++;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
        sme.xfer(OP_READ, a, 16'h0000, rd);
        chk(rd, exp);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        sme.xfer(OP_WRITE, a, d, rd);
    endtask
    task automatic t_forced;
        logic [15:0] w [4] = '{16'h203F, 16'h0040, 16'h0000, 16'h2140};
        logic [1:0]  s [4] = '{SPD_100, SPD_1000, SPD_10, SPD_10};
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CONTROL, w[i]);
            rdc(ADDR_CONTROL, w[i] & 16'hFFC0);
            chk(16'(cfg.speed), 16'(s[i]));
            chk(16'(cfg.full_duplex), 16'(w[i][8]));
        end
    endtask
    task automatic t_restart;
        wr(ADDR_CONTROL, 16'h0200);
        rdc(ADDR_CONTROL, 16'h0000);
        chk(16'(starts), 16'h0000);
        wr(ADDR_CONTROL, 16'h1200);
        chk(16'(starts), 16'h0001);
        chk(16'(cfg.speed), 16'(SPD_1000));
        wr(ADDR_CONTROL, 16'h1000);
        rdc(ADDR_CONTROL, 16'h1200);
        neg.an_initiated <= 1'b1;
        @(posedge mclk);
        neg.an_initiated <= 1'b0;
        rdc(ADDR_CONTROL, 16'h1000);
    endtask
    task automatic t_path;
        // Loopback at 10 Mb/s, so there is no descrambler dead time to wait out
        wr(ADDR_CONTROL, 16'h4000);
        chk(16'(mac_rx.rxd), 16'h00A5);
        chk(16'(line_tx), 16'h0000);
        chk(16'(rx_oe), 16'h0001);
        wr(ADDR_CONTROL, 16'h0400);
        chk(16'(rx_oe), 16'h0000);
        chk(16'(line_tx), 16'h0000);
        rdc(ADDR_CONTROL, 16'h0400);
        wr(ADDR_CONTROL, 16'h0800);
        chk(16'(line_tx), 16'h0000);
        chk(16'(mac_rx), 16'h0000);
        chk(16'(cfg.power_down), 16'h0001);
        rdc(ADDR_CONTROL, 16'h0800);
        wr(ADDR_CONTROL, 16'h0080);
        chk(16'(line_tx), 16'h0296);
        chk(16'(mac_rx.rxd), 16'h003C);
        chk(16'(mac_rx.col), 16'h0001);
        mac_tx.tx_en <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(16'(mac_rx.col), 16'h0000);
    endtask
    task automatic t_pages;
        wr(ADDR_NP_TX, 16'hFFFF);
        rdc(ADDR_NP_TX, 16'hBFFF);
        neg.np_rx <= 16'h9ABC;
        neg.np_rx_valid <= 1'b1;
        @(posedge mclk);
        neg.np_rx_valid <= 1'b0;
        rdc(ADDR_NP_RX, 16'h9ABC);
        wr(ADDR_CONTROL, 16'h8000);
        sme.xfer(OP_READ, ADDR_CONTROL, 16'h0000, rd);
        chk(16'(rd[15]), 16'h0001);
        repeat (RCYC) @(posedge mclk);
        rdc(ADDR_CONTROL, 16'h0140);
        rdc(ADDR_NP_TX, WORD_ZERO);
        rdc(ADDR_NP_RX, WORD_ZERO);
    endtask
    task automatic report_and_stop;
        if (err_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        mac_tx = '{txd: 8'hA5, tx_en: 1'b1, tx_er: 1'b0};
        line_rx = '0;
        line_rx.rxd = 8'h3C;
        neg = '0;
        neg.res_speed = SPD_1000;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        rdc(ADDR_CONTROL, 16'h0140);
        rdc(ADDR_GIG_EXT, GIG_EXT_VALUE);
        rdc(5'h03, WORD_ZERO);
        t_forced;
        t_restart;
        t_path;
        t_pages;
        report_and_stop;
    end
    initial begin
        #1000000;
        err_count++;
        report_and_stop;
    end
endmodule
